/* File: alarm_defines.svh */
// Behaviour
// - six office alarm outputs exist: critical, major and minor, each audible and visual.
// - major audible and major visual are fail-safe, so a dead or reset block shows them in alarm.
// - a visual closure stays latched once set and is released only after its failure has cleared.
// - separate telemetry closures for critical, major and minor feed the remote gatherer.
// - non-SONET onsets wait a holdoff programmable in whole seconds from 1 to 30.
// - the same delay gates audible, visual, message and telemetry alarm and status points.
// - every asserted alarm point stays active at least 20 seconds, a fixed figure.
// - after the holdoff each point is held 20 more seconds even if its condition vanishes.
// - non-SONET clears wait a clear delay programmable from 1 to 20 seconds.
// - SONET onsets use a soak of 1 to 30 seconds, 2 seconds after reset.
// - SONET clears use a soak of 1 to 20 seconds, 10 seconds after reset.
// - the remote alarm gateway poll interval is 10 to 60 seconds, 20 seconds after reset.
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_HOLDOFF   8'h00
`define OFS_CLRDLY    8'h04
`define OFS_SON_ON    8'h08
`define OFS_SON_CLR   8'h0C
`define OFS_POLL      8'h10
`define OFS_MODE      8'h14
`define OFS_STATUS    8'h18
`define OFS_INT_STAT  8'h1C
`define OFS_INT_MASK  8'h20
`define OFS_VIS_REL   8'h24

// ----------------------------------------------------------------
// reset values and ranges, in seconds
// ----------------------------------------------------------------
`define SEC_W         6
`define HOLDOFF_RST   6'h02
`define CLRDLY_RST    6'h0A
`define SON_ON_RST    6'h02
`define SON_CLR_RST   6'h0A
`define POLL_RST      6'h14
`define SEC_MIN       6'h01
`define ONSET_MAX     6'h1E
`define CLEAR_MAX     6'h14
`define POLL_MIN      6'h0A
`define POLL_MAX      6'h3C
`define MIN_DUR       6'h14
// major closure bits rest in alarm while the block is held in reset
`define OUT_RST       12'h012

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define NSEV          3
`define SEV_CRIT      0
`define SEV_MAJ       1
`define SEV_MIN       2
`define IRQ_W         7
`define IRQ_ON_LSB    0
`define IRQ_CLR_LSB   3
`define IRQ_POLL      6

// ----------------------------------------------------------------
// timebase
// ----------------------------------------------------------------
`define SEC_NS        1000000000
`define CLK_NS        5

`endif

/* File: alarm_pkg.sv */
`default_nettype none
package alarm_pkg;
	typedef enum logic [1:0]
	{
		PT_IDLE   = 2'b00,
		PT_HOLD   = 2'b01,
		PT_ACTIVE = 2'b10
	} point_state_t;
endpackage
`default_nettype wire

/* File: sec_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module sec_tick #(
	parameter int SEC_CYCLES = 200000000
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      tick
);
	generate
		if (SEC_CYCLES < 2)
		begin : g_chk
			$error("sec_tick needs at least two cycles per second");
		end
	endgenerate

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        tick_q;
	logic        tick_d;

	always_comb
	begin
		tick_d = 1'b0;
		cnt_d  = cnt_q + 32'h00000001;
		if (cnt_q == 32'(SEC_CYCLES - 1))
		begin
			cnt_d  = 32'h00000000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q  <= 32'h00000000;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_tick_single: assert property (@(posedge clk) disable iff (!rst_n)
		tick |=> !tick) else $error("second tick longer than one cycle");
endmodule
`default_nettype wire

/* File: alarm_point.sv */
`timescale 1ns/1ps
`include "alarm_defines.svh"
`default_nettype none
module alarm_point #(
	parameter int SEC_W = `SEC_W
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             tick,
	input  wire logic             cond,
	input  wire logic [SEC_W-1:0] onset_sec,
	input  wire logic [SEC_W-1:0] clear_sec,
	output logic                  active,
	output logic                  rise,
	output logic                  fall
);
	generate
		if (SEC_W < `SEC_W)
		begin : g_chk
			$error("alarm_point counters too narrow for the second figures");
		end
	endgenerate

	alarm_pkg::point_state_t st_q;
	alarm_pkg::point_state_t st_d;
	logic [SEC_W-1:0]        cnt_q;
	logic [SEC_W-1:0]        cnt_d;
	logic [SEC_W-1:0]        dur_q;
	logic [SEC_W-1:0]        dur_d;
	logic                    rise_q;
	logic                    rise_d;
	logic                    fall_q;
	logic                    fall_d;

	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		dur_d  = dur_q;
		rise_d = 1'b0;
		fall_d = 1'b0;
		case (st_q)
			alarm_pkg::PT_IDLE:
			begin
				cnt_d = '0;
				if (cond)
					st_d = alarm_pkg::PT_HOLD;
			end
			alarm_pkg::PT_HOLD:
			begin
				if (!cond)
				begin
					// early drop restarts the holdoff from zero
					st_d  = alarm_pkg::PT_IDLE;
					cnt_d = '0;
				end
				else if (tick)
				begin
					if (cnt_q + 1'b1 >= onset_sec)
					begin
						st_d   = alarm_pkg::PT_ACTIVE;
						rise_d = 1'b1;
						cnt_d  = '0;
						dur_d  = '0;
					end
					else
						cnt_d = SEC_W'(cnt_q + 1'b1);
				end
			end
			alarm_pkg::PT_ACTIVE:
			begin
				if (tick && dur_q < SEC_W'(`MIN_DUR))
					dur_d = SEC_W'(dur_q + 1'b1);
				if (cond)
					cnt_d = '0;
				else if (tick && cnt_q < clear_sec)
					cnt_d = SEC_W'(cnt_q + 1'b1);
				// stretch holds even after the condition is gone
				if (!cond && dur_q >= SEC_W'(`MIN_DUR) && cnt_q >= clear_sec)
				begin
					st_d   = alarm_pkg::PT_IDLE;
					fall_d = 1'b1;
					cnt_d  = '0;
				end
			end
			default:
			begin
				st_d  = alarm_pkg::PT_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q   <= alarm_pkg::PT_IDLE;
			cnt_q  <= '0;
			dur_q  <= '0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			dur_q  <= dur_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end

	assign active = (st_q == alarm_pkg::PT_ACTIVE);
	assign rise   = rise_q;
	assign fall   = fall_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_early_drop;
		(st_q == alarm_pkg::PT_HOLD) && !cond;
	endsequence
	property p_cancel;
		@(posedge clk) disable iff (!rst_n)
		s_early_drop |=> (st_q == alarm_pkg::PT_IDLE) && !active && cnt_q == '0;
	endproperty
	a_hold_cancel: assert property (p_cancel) else $error("holdoff not restarted on drop");

	a_min_duration: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(active) |-> $past(dur_q) >= SEC_W'(`MIN_DUR)) else $error("alarm shorter than minimum");

	a_onset_cause: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(active) |-> $past(cond) && $past(tick) && rise) else $error("onset without held cause");

	a_clear_cause: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(active) |-> !$past(cond) && $past(cnt_q) >= $past(clear_sec) && fall)
		else $error("clear before clear delay");
endmodule
`default_nettype wire

/* File: office_alarm_timing_controller.sv */
`timescale 1ns/1ps
`include "alarm_defines.svh"
`default_nettype none
module office_alarm_timing_controller #(
	parameter int SEC_CYCLES = `SEC_NS / `CLK_NS
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic [`NSEV-1:0]  fail_cond,
	output logic                   critical_audible,
	output logic                   critical_visual,
	output logic                   major_audible_n,
	output logic                   major_visual_n,
	output logic                   minor_audible,
	output logic                   minor_visual,
	output logic [`NSEV-1:0]       telemetry_alarm,
	output logic [`NSEV-1:0]       telemetry_status,
	output logic                   message_req,
	output logic                   remote_alarm_gateway_poll,
	output logic                   irq
);
	generate
		if (SEC_CYCLES < 2)
		begin : g_chk
			$error("SEC_CYCLES too small for a one-second base");
		end
	endgenerate

	// ----------------------------------------------------------------
	// timebase and alarm points
	// ----------------------------------------------------------------
	logic                 tick;
	logic [`NSEV-1:0]     act;
	logic [`NSEV-1:0]     rise;
	logic [`NSEV-1:0]     fall;
	logic [`SEC_W-1:0]    holdoff_q;
	logic [`SEC_W-1:0]    clrdly_q;
	logic [`SEC_W-1:0]    son_on_q;
	logic [`SEC_W-1:0]    son_clr_q;
	logic [`SEC_W-1:0]    poll_q;
	logic [`NSEV-1:0]     mode_q;

	sec_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
		.clk   (pclk),
		.rst_n (presetn),
		.tick  (tick)
	);

	genvar g;
	generate
		for (g = 0; g < `NSEV; g++)
		begin : g_pt
			// mode bit picks SONET soak figures over the office holdoff
			alarm_point #(.SEC_W(`SEC_W)) u_pt (
				.clk       (pclk),
				.rst_n     (presetn),
				.tick      (tick),
				.cond      (fail_cond[g]),
				.onset_sec (mode_q[g] ? son_on_q : holdoff_q),
				.clear_sec (mode_q[g] ? son_clr_q : clrdly_q),
				.active    (act[g]),
				.rise      (rise[g]),
				.fall      (fall[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic       wr;
	logic       rd_setup;
	logic       mapped;
	logic       bad_val;
	logic [5:0] wval;

	assign wval = pwdata[5:0];
	assign wr = psel && penable && pwrite && !pslverr;
	assign rd_setup = psel && !penable && !pwrite;

	always_comb
	begin
		mapped  = 1'b1;
		bad_val = 1'b0;
		case (paddr)
			`OFS_HOLDOFF, `OFS_SON_ON:
				bad_val = wval < `SEC_MIN || wval > `ONSET_MAX || pwdata[31:6] != '0;
			`OFS_CLRDLY, `OFS_SON_CLR:
				bad_val = wval < `SEC_MIN || wval > `CLEAR_MAX || pwdata[31:6] != '0;
			`OFS_POLL:
				bad_val = wval < `POLL_MIN || wval > `POLL_MAX || pwdata[31:6] != '0;
			`OFS_MODE, `OFS_STATUS, `OFS_INT_STAT, `OFS_INT_MASK, `OFS_VIS_REL:
				bad_val = 1'b0;
			default:
				mapped = 1'b0;
		endcase
	end

	// zero wait states; out-of-range settings are refused, not clamped
	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!mapped || (pwrite && bad_val));

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [`SEC_W-1:0] holdoff_d;
	logic [`SEC_W-1:0] clrdly_d;
	logic [`SEC_W-1:0] son_on_d;
	logic [`SEC_W-1:0] son_clr_d;
	logic [`SEC_W-1:0] poll_d;
	logic [`NSEV-1:0]  mode_d;
	logic [`IRQ_W-1:0] imask_q;
	logic [`IRQ_W-1:0] imask_d;

	always_comb
	begin
		holdoff_d = holdoff_q;
		clrdly_d  = clrdly_q;
		son_on_d  = son_on_q;
		son_clr_d = son_clr_q;
		poll_d    = poll_q;
		mode_d    = mode_q;
		imask_d   = imask_q;
		if (wr)
		begin
			case (paddr)
				`OFS_HOLDOFF:  holdoff_d = wval;
				`OFS_CLRDLY:   clrdly_d  = wval;
				`OFS_SON_ON:   son_on_d  = wval;
				`OFS_SON_CLR:  son_clr_d = wval;
				`OFS_POLL:     poll_d    = wval;
				`OFS_MODE:     mode_d    = pwdata[`NSEV-1:0];
				`OFS_INT_MASK: imask_d   = pwdata[`IRQ_W-1:0];
				default:       mode_d    = mode_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			holdoff_q <= `HOLDOFF_RST;
			clrdly_q  <= `CLRDLY_RST;
			son_on_q  <= `SON_ON_RST;
			son_clr_q <= `SON_CLR_RST;
			poll_q    <= `POLL_RST;
			mode_q    <= '0;
			imask_q   <= '0;
		end
		else
		begin
			holdoff_q <= holdoff_d;
			clrdly_q  <= clrdly_d;
			son_on_q  <= son_on_d;
			son_clr_q <= son_clr_d;
			poll_q    <= poll_d;
			mode_q    <= mode_d;
			imask_q   <= imask_d;
		end
	end

	// ----------------------------------------------------------------
	// gateway poll timer
	// ----------------------------------------------------------------
	logic [`SEC_W-1:0] pcnt_q;
	logic [`SEC_W-1:0] pcnt_d;
	logic              poll_ev;

	always_comb
	begin
		pcnt_d  = pcnt_q;
		poll_ev = 1'b0;
		if (tick)
		begin
			if (pcnt_q + 1'b1 >= poll_q)
			begin
				pcnt_d  = '0;
				poll_ev = 1'b1;
			end
			else
				pcnt_d = `SEC_W'(pcnt_q + 1'b1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pcnt_q <= '0;
		else
			pcnt_q <= pcnt_d;
	end

	// ----------------------------------------------------------------
	// visual latches, interrupts, outputs
	// ----------------------------------------------------------------
	logic [`NSEV-1:0]  vis_q;
	logic [`NSEV-1:0]  vis_d;
	logic [`IRQ_W-1:0] ist_q;
	logic [`IRQ_W-1:0] ist_d;
	logic [`IRQ_W-1:0] ev;
	logic [`NSEV-1:0]  rel;
	logic [11:0]       out_q;
	logic [11:0]       out_d;
	logic [2:0]        misc_q;
	logic [2:0]        misc_d;
	logic [31:0]       prdata_q;
	logic [31:0]       prdata_d;

	assign ev  = {poll_ev, fall, rise};
	assign rel = (wr && paddr == `OFS_VIS_REL) ? pwdata[`NSEV-1:0] : '0;

	always_comb
	begin
		// release only once the point is idle and the failure gone; a new set wins
		vis_d = (vis_q & ~(rel & ~act & ~fail_cond)) | act;
		ist_d = ist_q & ~((wr && paddr == `OFS_INT_STAT) ? pwdata[`IRQ_W-1:0] : '0);
		ist_d = ist_d | ev;
		out_d = {act, act, vis_d, act};
		misc_d = {|(ist_q & imask_q), |rise, poll_ev};
		prdata_d = prdata_q;
		if (rd_setup)
		begin
			case (paddr)
				`OFS_HOLDOFF:  prdata_d = {26'h0, holdoff_q};
				`OFS_CLRDLY:   prdata_d = {26'h0, clrdly_q};
				`OFS_SON_ON:   prdata_d = {26'h0, son_on_q};
				`OFS_SON_CLR:  prdata_d = {26'h0, son_clr_q};
				`OFS_POLL:     prdata_d = {26'h0, poll_q};
				`OFS_MODE:     prdata_d = {29'h0, mode_q};
				`OFS_STATUS:   prdata_d = {23'h0, fail_cond, vis_q, act};
				`OFS_INT_STAT: prdata_d = {25'h0, ist_q};
				`OFS_INT_MASK: prdata_d = {25'h0, imask_q};
				default:       prdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vis_q    <= '0;
			ist_q    <= '0;
			out_q    <= `OUT_RST;
			misc_q   <= 3'h0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			vis_q    <= vis_d;
			ist_q    <= ist_d;
			out_q    <= out_d;
			misc_q   <= misc_d;
			prdata_q <= prdata_d;
		end
	end

	// six office closures from the delayed, stretched points
	assign critical_audible = out_q[`SEV_CRIT];
	assign minor_audible    = out_q[`SEV_MIN];
	assign critical_visual  = out_q[3 + `SEV_CRIT];
	assign minor_visual     = out_q[3 + `SEV_MIN];
	// major relays are held energised when healthy, so reset or power loss alarms
	assign major_audible_n  = ~out_q[`SEV_MAJ];
	assign major_visual_n   = ~out_q[3 + `SEV_MAJ];
	assign telemetry_alarm  = out_q[8:6];
	assign telemetry_status = out_q[11:9];
	assign message_req      = misc_q[1];
	assign remote_alarm_gateway_poll = misc_q[0];
	assign irq              = misc_q[2];
	assign prdata           = prdata_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_major_failsafe: assert property (@(posedge pclk) disable iff (!presetn)
		act[`SEV_MAJ] |=> !major_audible_n && !major_visual_n) else $error("major not in alarm");

	a_visual_latched: assert property (@(posedge pclk) disable iff (!presetn)
		(vis_q[0] && !rel[0]) |=> critical_visual) else $error("visual dropped without release");

	a_visual_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(vis_q[2] && fail_cond[2]) |=> vis_q[2]) else $error("visual released while failing");

	a_telem_follow: assert property (@(posedge pclk) disable iff (!presetn)
		act == $past(act) |=> telemetry_alarm == $past(act, 2) && telemetry_status == telemetry_alarm)
		else $error("telemetry not matching point");

	a_range_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && paddr == `OFS_HOLDOFF && wval > `ONSET_MAX) |=> $stable(holdoff_q))
		else $error("out-of-range holdoff taken");

	a_poll_range: assert property (@(posedge pclk) disable iff (!presetn)
		poll_q >= `POLL_MIN && poll_q <= `POLL_MAX && son_clr_q <= `CLEAR_MAX)
		else $error("timer setting out of range");

	a_msg_onset: assert property (@(posedge pclk) disable iff (!presetn)
		|rise |=> message_req && ist_q[`IRQ_ON_LSB +: `NSEV] != '0) else $error("onset not reported");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		##1 irq == |($past(ist_q) & $past(imask_q))) else $error("irq not following status");
endmodule
`default_nettype wire

/* File: alarm_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// office panel and telemetry gatherer: measures each telemetry alarm closure
// ----------------------------------------------------------------
module alarm_panel_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [2:0]  telemetry_alarm,
	output logic      [15:0] last_len [3]
);
	logic [15:0] run_q [3];
	// a gatherer only sees whole closures, so the length is kept at each release
	always_ff @(posedge pclk or negedge presetn)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (!presetn)
			begin
				run_q[i]    <= 16'h0000;
				last_len[i] <= 16'h0000;
			end
			else if (telemetry_alarm[i])
				run_q[i] <= run_q[i] + 16'h0001;
			else if (run_q[i] != 16'h0000)
			begin
				last_len[i] <= run_q[i];
				run_q[i]    <= 16'h0000;
			end
		end
	end
endmodule
`default_nettype wire

/* File: office_alarm_timing_controller_tb.sv */
`timescale 1ns/1ps
`include "alarm_defines.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module office_alarm_timing_controller_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [2:0]  fail_cond = 3'h0;
	logic        critical_audible;
	logic        critical_visual;
	logic        major_audible_n;
	logic        major_visual_n;
	logic        minor_audible;
	logic        minor_visual;
	logic [2:0]  telemetry_alarm;
	logic [2:0]  telemetry_status;
	logic        message_req;
	logic        remote_alarm_gateway_poll;
	logic        irq;
	logic [15:0] panel_len [3];
	int          err_count = 0;
	int          checks = 0;
	int          cyc = 0;

	// ----------------------------------------------------------------
	// clock, timeout and instances
	// ----------------------------------------------------------------
	always #2.5 pclk = ~pclk;
	// short second keeps the 20 s stretch near two hundred cycles
	office_alarm_timing_controller #(.SEC_CYCLES(10)) u_office_alarm_timing_controller (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.fail_cond(fail_cond), .critical_audible(critical_audible), .critical_visual(critical_visual),
		.major_audible_n(major_audible_n), .major_visual_n(major_visual_n),
		.minor_audible(minor_audible), .minor_visual(minor_visual),
		.telemetry_alarm(telemetry_alarm), .telemetry_status(telemetry_status),
		.message_req(message_req), .remote_alarm_gateway_poll(remote_alarm_gateway_poll), .irq(irq));
	alarm_panel_model u_alarm_panel_model (
		.pclk(pclk), .presetn(presetn), .telemetry_alarm(telemetry_alarm), .last_len(panel_len));
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_count++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic aud(input int n);
		return (n == 0) ? critical_audible : (n == 1) ? ~major_audible_n : minor_audible;
	endfunction
	function automatic logic vis(input int n);
		return (n == 0) ? critical_visual : (n == 1) ? ~major_visual_n : minor_visual;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e,
		output logic [31:0] r);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prdata;
		`CHK("pready", 1'b1, pready)
		`CHK("pslverr", e, pslverr)
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] r;
		apb(1'b1, a, d, e, r);
	endtask
	task automatic wait_aud(input int n, input logic v, output int k);
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (aud(n) !== v && k < 400);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reset_regs();
		logic [7:0]  ofs [7] = '{`OFS_HOLDOFF, `OFS_CLRDLY, `OFS_SON_ON, `OFS_SON_CLR, `OFS_POLL,
			`OFS_MODE, `OFS_INT_MASK};
		logic [5:0]  rv [7] = '{`HOLDOFF_RST, `CLRDLY_RST, `SON_ON_RST, `SON_CLR_RST, `POLL_RST,
			6'h00, 6'h00};
		logic [31:0] r;
		`CHK("major_aud_rst", 1'b0, major_audible_n)
		`CHK("major_vis_rst", 1'b0, major_visual_n)
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK("major_aud_run", 1'b1, major_audible_n)
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b0, ofs[i], 32'h0000_0000, 1'b0, r);
			`CHK("reset_value", {26'h0, rv[i]}, r)
		end
		apb(1'b0, 8'h28, 32'h0000_0000, 1'b1, r);
		`CHK("unmapped", 32'h0000_0000, r)
		wr(`OFS_HOLDOFF, 32'h0000_001F, 1'b1);
		wr(`OFS_HOLDOFF, 32'h0000_0000, 1'b1);
		wr(`OFS_SON_CLR, 32'h0000_0015, 1'b1);
		wr(`OFS_POLL, 32'h0000_0009, 1'b1);
		apb(1'b0, `OFS_HOLDOFF, 32'h0000_0000, 1'b0, r);
		`CHK("refused_wr", 32'h0000_0002, r)
		$display("reset and registers done");
	endtask
	task automatic sev_test(input int n, input int lo, input int hi);
		int          k;
		logic        sn;
		logic [31:0] r;
		wr(`OFS_INT_MASK, 32'h1 << n, 1'b0);
		fail_cond[n] <= 1'b1;
		repeat (lo - 5) @(posedge pclk);
		fail_cond[n] <= 1'b0;
		sn = 1'b0;
		repeat (40)
		begin
			@(posedge pclk);
			sn = sn | aud(n) | telemetry_alarm[n] | message_req;
		end
		`CHK("cancel", 1'b0, sn)
		fail_cond[n] <= 1'b1;
		wait_aud(n, 1'b1, k);
		`CHK("onset", 1'b1, (k >= lo && k <= hi))
		`CHK("telem", 1'b1, telemetry_alarm[n])
		`CHK("status", 1'b1, telemetry_status[n])
		`CHK("visual", 1'b1, vis(n))
		`CHK("message", 1'b1, message_req)
		fail_cond[n] <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK("irq_set", 1'b1, irq)
		wait_aud(n, 1'b0, k);
		`CHK("stretch", 1'b1, (k >= 185 && k <= 215))
		@(posedge pclk);
		`CHK("panel_len", 1'b1, (panel_len[n] >= 16'h00C8))
		`CHK("latched", 1'b1, vis(n))
		apb(1'b0, `OFS_STATUS, 32'h0000_0000, 1'b0, r);
		`CHK("status_latch", 32'h0000_0008 << n, r)
		wr(`OFS_VIS_REL, 32'h1 << n, 1'b0);
		@(posedge pclk);
		`CHK("released", 1'b0, vis(n))
		wr(`OFS_INT_STAT, 32'h0000_007F, 1'b0);
		repeat (2) @(posedge pclk);
		`CHK("irq_clr", 1'b0, irq)
		$display("severity %0d done", n);
	endtask
	task automatic poll_test();
		int k;
		wr(`OFS_POLL, 32'h0000_000A, 1'b0);
		k = 0;
		while (remote_alarm_gateway_poll !== 1'b1 && k < 700)
		begin
			@(posedge pclk);
			k++;
		end
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (remote_alarm_gateway_poll !== 1'b1 && k < 700);
		`CHK("poll_gap", 100, k)
		$display("poll done");
	endtask

	initial
	begin
		repeat (3) @(posedge pclk);
		reset_regs();
		wr(`OFS_HOLDOFF, 32'h0000_0003, 1'b0);
		for (int n = 0; n < 3; n++)
			sev_test(n, 20, 34);
		wr(`OFS_HOLDOFF, 32'h0000_001E, 1'b0);
		wr(`OFS_MODE, 32'h0000_0001, 1'b0);
		sev_test(0, 10, 24);
		poll_test();
		end_of_test();
	end
endmodule
`default_nettype wire
